/* File: core/kpo_defs.vh */
// Constants for the keypad, status LED and switching output controller
`ifndef KPO_DEFS_VH
`define KPO_DEFS_VH
`define KPO_CLK_HZ 200000000
`define KPO_LONG_MS 2000
`define KPO_BOOT_MS 90001
`define KPO_TICK_HZ 1000
`define KPO_TICK_DIV (`KPO_CLK_HZ / `KPO_TICK_HZ)
`define KPO_DEB_MS 20
`define KPO_FLASH_MS 250
`define KPO_NKEYS 5
`define KPO_KEY_INT 0
`define KPO_KEY_TEACH 1
`define KPO_KEY_AUTO 2
`define KPO_KEY_ENTER 3
`define KPO_KEY_ESC 4
`define KPO_DRV_SINK 2'b00
`define KPO_DRV_SOURCE 2'b01
`define KPO_DRV_PUSH_PULL 2'b10
`define KPO_ADDR_CTRL 12'h000
`define KPO_ADDR_COLOUR 12'h004
`define KPO_ADDR_STATUS 12'h008
`define KPO_ADDR_EVENT 12'h00C
`define KPO_CTRL_RESET 32'h0000_00FF
`endif

/* File: core/kpo_key_timer.v */
// One key: synchroniser, debounce and short or long press classifier
`timescale 1ns/1ps
`default_nettype none
module kpo_key_timer #(
  parameter DEB_TICKS = 20,
  parameter LONG_TICKS = 2000
) (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire key_raw,
  output reg key_level,
  output reg short_pulse,
  output reg long_pulse,
  output reg long_held
);
  reg sync_a;
  reg sync_b;
  reg [7:0] deb_cnt;
  reg [11:0] hold_cnt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      deb_cnt <= 8'h00;
      key_level <= 1'b0;
      hold_cnt <= 12'h000;
      short_pulse <= 1'b0;
      long_pulse <= 1'b0;
      long_held <= 1'b0;
    end else begin
      sync_a <= key_raw;
      sync_b <= sync_a;
      short_pulse <= 1'b0;
      long_pulse <= 1'b0;
      // Debounce on millisecond ticks
      if (sync_b == key_level) begin // [R14]
        deb_cnt <= 8'h00;
      end else if (tick) begin
        if (deb_cnt == DEB_TICKS[7:0] - 8'h01) begin
          deb_cnt <= 8'h00;
          key_level <= sync_b;
        end else begin
          deb_cnt <= deb_cnt + 8'h01;
        end
      end
      if (key_level) begin
        if (tick && !long_held) begin
          if (hold_cnt == LONG_TICKS[11:0] - 12'h001) begin
            long_held <= 1'b1; // [R1] [R2]
          end else begin
            hold_cnt <= hold_cnt + 12'h001;
          end
        end
      end else begin
        hold_cnt <= 12'h000;
        long_held <= 1'b0;
      end
      // Act on release only
      if (!sync_b && key_level && deb_cnt == DEB_TICKS[7:0] - 8'h01 && tick) begin // [R3]
        short_pulse <= ~long_held;
        long_pulse <= long_held;
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/kpo_panel.v */
// Front panel: key handling, key lock, status LEDs and switching outputs
//
// Overview of operation
// [R1] A key held for two seconds changes from its short to its long function.
// [R2] From the long threshold the key LED is lit steadily until release.
// [R3] A function, short or long, fires once, on the key release.
// [R4] A long press of any key but escape opens the key's menu, short presses act only inside a menu.
// [R5] The sequence escape, enter, escape toggles the key lock.
// [R6] During boot the green LED flashes and the red LED is on.
// [R7] In operating mode the red LED is off and the green LED is steady.
// [R8] Keys are dead for the boot phase of over 90 s; outputs run at once.
// [R9] With no taught colour every line shows a configurable default level, high from reset.
// [R10] Lines show the colour one line per entry or as a binary code.
// [R11] All lines follow the chosen sinking, sourcing or push-pull style.
// [R12] In a menu a long enter commits changes and returns to operating mode.
// [R13] In a menu a long escape discards changes and returns to operating mode.
// [R14] Keys are synchronised and debounced and timed on a prescaled tick.
// [R15] While locked, every key action but the lock sequence is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "kpo_defs.vh"
module kpo_panel #(
  parameter LINES = 8,
  parameter TICK_DIV = `KPO_TICK_DIV,
  parameter BOOT_TICKS = `KPO_BOOT_MS,
  parameter LONG_TICKS = `KPO_LONG_MS,
  parameter DEB_TICKS = `KPO_DEB_MS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [4:0] key_raw,
  output reg [4:0] key_led,
  output reg led_green,
  output reg led_red,
  output reg [LINES-1:0] switch_line_out,
  output reg [LINES-1:0] switch_line_oe
);
  localparam ST_BOOT = 3'b001;
  localparam ST_OPER = 3'b010;
  localparam ST_MENU = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Tick prescaler and boot timer
  reg [31:0] pre_cnt;
  reg tick;
  reg [31:0] boot_cnt;
  reg [2:0] state;
  reg [8:0] flash_cnt;
  reg flash;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 32'h0000_0000;
      tick <= 1'b0;
      flash_cnt <= 9'h000;
      flash <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_cnt == TICK_DIV - 1) begin // [R14]
        pre_cnt <= 32'h0000_0000;
        tick <= 1'b1;
        if (flash_cnt == `KPO_FLASH_MS - 1) begin
          flash_cnt <= 9'h000;
          flash <= ~flash;
        end else begin
          flash_cnt <= flash_cnt + 9'h001;
        end
      end else begin
        pre_cnt <= pre_cnt + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-key timing
  wire [4:0] lvl;
  wire [4:0] sp;
  wire [4:0] lp;
  wire [4:0] lh;
  genvar g;
  generate
    for (g = 0; g < `KPO_NKEYS; g = g + 1) begin : key
      kpo_key_timer #(.DEB_TICKS(DEB_TICKS), .LONG_TICKS(LONG_TICKS)) u_key (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .key_raw(key_raw[g]),
        .key_level(lvl[g]),
        .short_pulse(sp[g]),
        .long_pulse(lp[g]),
        .long_held(lh[g])
      );
    end
  endgenerate
  wire any_evt = |(sp | lp);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  reg [LINES-1:0] default_level;
  reg binary_mode;
  reg [1:0] drive_style;
  reg colour_valid;
  reg [7:0] colour_idx;
  reg locked;
  reg [1:0] seq;
  reg [2:0] menu_key;
  reg [4:0] evt_short;
  reg [4:0] evt_long;
  reg commit_flag;
  reg discard_flag;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd_ev = acc && !pwrite && paddr == `KPO_ADDR_EVENT;
  wire keys_live = (state != ST_BOOT); // [R8]
  wire [4:0] sp_ok = locked ? 5'h00 : sp; // [R15]
  wire [4:0] lp_ok = locked ? 5'h00 : lp; // [R15]
  wire long_enter = keys_live && lp_ok[`KPO_KEY_ENTER];
  wire long_esc = keys_live && lp_ok[`KPO_KEY_ESC];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_BOOT;
      boot_cnt <= 32'h0000_0000;
      locked <= 1'b0;
      seq <= 2'b00;
      menu_key <= 3'b000;
      commit_flag <= 1'b0;
      discard_flag <= 1'b0;
      evt_short <= 5'h00;
      evt_long <= 5'h00;
    end else begin
      // Lock sequence, watched on every release after boot
      if (keys_live && any_evt) begin
        if ((sp[`KPO_KEY_ESC] || lp[`KPO_KEY_ESC]) && seq == 2'b10) begin
          locked <= ~locked; // [R5]
          seq <= 2'b00;
        end else if (sp[`KPO_KEY_ESC] || lp[`KPO_KEY_ESC]) begin
          seq <= 2'b01;
        end else if ((sp[`KPO_KEY_ENTER] || lp[`KPO_KEY_ENTER]) && seq == 2'b01) begin
          seq <= 2'b10;
        end else begin
          seq <= 2'b00;
        end
      end
      // Event flags: set wins over read clear
      // Only bits already latched into prdata are cleared, so a later event survives
      evt_short <= (rd_ev ? evt_short & ~prdata[4:0] : evt_short)
        | (state == ST_MENU ? sp_ok : 5'h00); // [R4]
      evt_long <= (rd_ev ? evt_long & ~prdata[9:5] : evt_long) | (keys_live ? lp_ok : 5'h00);
      commit_flag <= (rd_ev ? commit_flag & ~prdata[11] : commit_flag)
        | (state == ST_MENU && long_enter);
      discard_flag <= (rd_ev ? discard_flag & ~prdata[10] : discard_flag)
        | (state == ST_MENU && long_esc);
      case (state)
        ST_BOOT: begin
          if (tick) begin
            if (boot_cnt == BOOT_TICKS - 1) begin
              state <= ST_OPER; // [R8]
            end else begin
              boot_cnt <= boot_cnt + 32'h0000_0001;
            end
          end
        end
        ST_OPER: begin
          if (keys_live && (lp_ok & ~(5'h01 << `KPO_KEY_ESC)) != 5'h00) begin
            state <= ST_MENU; // [R4]
            menu_key <= lp_ok[0] ? 3'd0 : lp_ok[1] ? 3'd1 : lp_ok[2] ? 3'd2 : 3'd3;
          end
        end
        ST_MENU: begin
          if (long_enter || long_esc) begin
            state <= ST_OPER; // [R12] [R13]
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      default_level <= {LINES{1'b1}};
      binary_mode <= 1'b0;
      drive_style <= `KPO_DRV_PUSH_PULL;
      colour_valid <= 1'b0;
      colour_idx <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `KPO_ADDR_CTRL: prdata <= {21'h00_0000, drive_style, binary_mode, default_level[7:0]};
          `KPO_ADDR_COLOUR: prdata <= {23'h00_0000, colour_valid, colour_idx};
          `KPO_ADDR_STATUS: prdata <= {24'h00_0000, 1'b0, seq, locked, menu_key, state == ST_OPER};
          `KPO_ADDR_EVENT: prdata <= {20'h0_0000, commit_flag, discard_flag, evt_long, evt_short};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (wr && pready && paddr == `KPO_ADDR_CTRL) begin
        default_level <= pwdata[LINES-1:0]; // [R9]
        binary_mode <= pwdata[8]; // [R10]
        drive_style <= pwdata[10:9]; // [R11]
      end
      if (wr && pready && paddr == `KPO_ADDR_COLOUR) begin
        colour_idx <= pwdata[7:0];
        colour_valid <= pwdata[8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching outputs and LEDs
  reg [LINES-1:0] next_level;
  integer i;
  always @* begin
    next_level = default_level; // [R9]
    if (colour_valid) begin
      if (binary_mode) begin
        next_level = colour_idx[LINES-1:0]; // [R10]
      end else begin
        for (i = 0; i < LINES; i = i + 1) begin
          next_level[i] = (colour_idx == i); // [R10]
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_line_out <= {LINES{1'b0}};
      switch_line_oe <= {LINES{1'b0}};
      led_green <= 1'b0;
      led_red <= 1'b1;
      key_led <= 5'h00;
    end else begin
      case (drive_style) // [R11]
        `KPO_DRV_SINK: begin
          switch_line_out <= {LINES{1'b0}};
          switch_line_oe <= ~next_level;
        end
        `KPO_DRV_SOURCE: begin
          switch_line_out <= {LINES{1'b1}};
          switch_line_oe <= next_level;
        end
        default: begin
          switch_line_out <= next_level;
          switch_line_oe <= {LINES{1'b1}};
        end
      endcase
      led_green <= (state == ST_BOOT) ? flash : 1'b1; // [R6] [R7]
      led_red <= (state == ST_BOOT); // [R6] [R7]
      key_led <= (keys_live && !locked) ? (lh & lvl) : 5'h00; // [R2]
    end
  end
endmodule
`default_nettype wire

/* File: dv/kpo_panel_assertions.sv */
// Port checker for the front panel controller
`timescale 1ns/1ps
`default_nettype none
module kpo_chk #(parameter LINES = 8) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [4:0] key_raw,
  input wire [4:0] key_led,
  input wire led_green,
  input wire led_red,
  input wire [LINES-1:0] switch_line_out,
  input wire [LINES-1:0] switch_line_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  apb_answer_a: assert property (s_setup |=> s_done) else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  red_latch_a: assert property (!led_red |=> !led_red) else $error("red back on");
  green_steady_a: assert property (!led_red && !$past(led_red, 2) |-> led_green)
    else $error("green not steady");
  boot_keys_dead_a: assert property (led_red |-> key_led == 5'h00)
    else $error("key led in boot");
  led_press_a: assert property ($rose(|key_led) |-> |key_raw)
    else $error("key led without key");
  led_release_a: assert property ((key_led & ~key_raw) != 5'h00 |-> ##[0:20] key_led == 5'h00)
    else $error("key led stuck");
  one_style_a: assert property (&switch_line_oe || !(|switch_line_out) || &switch_line_out)
    else $error("mixed drive style");
  reset_level_a: assert property ($rose(presetn) |-> ##[1:3] &{switch_line_out, switch_line_oe})
    else $error("lines not high");
endmodule
`default_nettype wire

/* File: dv/kpo_pad_model.sv */
// Membrane keypad and switching output load
`timescale 1ns/1ps
`default_nettype none
module kpo_pad_model #(parameter TICK_DIV = 4) (
  input wire pclk,
  output logic [4:0] key_raw,
  input wire [7:0] line_out,
  input wire [7:0] line_oe,
  input wire pull,
  output wire [7:0] pin
);
  initial key_raw = 5'h00;
  // A released line settles to the load resistor level
  assign pin = (line_oe & line_out) | (~line_oe & {8{pull}});
  task automatic hold(input int k, input int n);
    key_raw[k] <= 1'b1;
    repeat (n * TICK_DIV) @(posedge pclk);
  endtask
  task automatic rel(input int k);
    key_raw[k] <= 1'b0;
    repeat (10 * TICK_DIV) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: dv/keypad_status_output_ctrl_tb.sv */
// Self-checking bench for the front panel controller
`timescale 1ns/1ps
`default_nettype none
`include "kpo_defs.vh"
module keypad_status_output_ctrl_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pull = 0;
  logic pready, pslverr, led_green, led_red, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [4:0] key_raw, key_led;
  logic [7:0] out, oe, pin;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  kpo_panel #(.TICK_DIV(4), .BOOT_TICKS(20), .LONG_TICKS(10), .DEB_TICKS(2)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_raw(key_raw), .key_led(key_led), .led_green(led_green), .led_red(led_red),
    .switch_line_out(out), .switch_line_oe(oe));
  kpo_pad_model u_pad (.pclk(pclk), .key_raw(key_raw), .line_out(out), .line_oe(oe),
    .pull(pull), .pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so a following call never re-raises psel in the same step
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  task automatic tap(input int k, input int n);
    u_pad.hold(k, n);
    chk(key_led, 5'h00);
    u_pad.rel(k);
  endtask
  task automatic long_press(input int k);
    u_pad.hold(k, 16);
    chk(key_led, 5'h01 << k);
    u_pad.rel(k);
  endtask
  task automatic lock_seq;
    tap(4, 5);
    tap(3, 5);
    tap(4, 5);
  endtask
  task automatic t_boot;
    chk(led_red, 1'h1);
    u_pad.hold(3, 12);
    chk(key_led, 5'h00);
    u_pad.rel(3);
  endtask
  task automatic t_oper;
    int t = 0;
    while (led_red !== 1'b0 && t < 400) begin
      @(posedge pclk);
      t++;
    end
    repeat (4) @(posedge pclk);
    chk(led_green, 1'h1);
    rdc(`KPO_ADDR_STATUS, 32'h0000_001f, 32'h0000_0001);
    rdc(`KPO_ADDR_EVENT, 32'hffff_ffff, 32'h0000_0000);
  endtask
  task automatic t_lock;
    lock_seq;
    rdc(`KPO_ADDR_STATUS, 32'h0000_0011, 32'h0000_0011);
    tap(0, 16);
    rdc(`KPO_ADDR_EVENT, 32'hffff_ffff, 32'h0000_0000);
    lock_seq;
    rdc(`KPO_ADDR_STATUS, 32'h0000_0011, 32'h0000_0001);
  endtask
  task automatic t_menu;
    tap(2, 5);
    rdc(`KPO_ADDR_EVENT, 32'hffff_ffff, 32'h0000_0000);
    long_press(0);
    rdc(`KPO_ADDR_STATUS, 32'h0000_000f, 32'h0000_0000);
    rdc(`KPO_ADDR_EVENT, 32'hffff_ffff, 32'h0000_0020);
    tap(2, 7);
    rdc(`KPO_ADDR_EVENT, 32'hffff_ffff, 32'h0000_0004);
    long_press(3);
    rdc(`KPO_ADDR_EVENT, 32'h0000_0800, 32'h0000_0800);
    rdc(`KPO_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    long_press(1);
    rdc(`KPO_ADDR_STATUS, 32'h0000_000f, 32'h0000_0002);
    long_press(4);
    rdc(`KPO_ADDR_EVENT, 32'h0000_0400, 32'h0000_0400);
    rdc(`KPO_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
  endtask
  task automatic t_lines;
    logic [7:0] eo[3] = '{8'h00, 8'hff, 8'h5a};
    logic [7:0] ee[3] = '{8'ha5, 8'h5a, 8'hff};
    chk({oe, out}, 16'hffff);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `KPO_ADDR_CTRL, 32'h0000_005a | (s << 9));
      pull <= (s == 0);
      repeat (3) @(posedge pclk);
      chk({oe, out}, {ee[s], eo[s]});
      chk(pin, 8'h5a);
    end
    apb(1'b1, `KPO_ADDR_COLOUR, 32'h0000_0103);
    repeat (3) @(posedge pclk);
    chk(out, 8'h08);
    apb(1'b1, `KPO_ADDR_CTRL, 32'h0000_055a);
    repeat (3) @(posedge pclk);
    chk(out, 8'h03);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(err, 1'h1);
    chk(rd, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot;
    t_oper;
    t_lock;
    t_menu;
    t_lines;
    tally_and_finish;
  end
endmodule
bind kpo_panel kpo_chk #(.LINES(LINES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .key_raw(key_raw), .key_led(key_led),
  .led_green(led_green), .led_red(led_red), .switch_line_out(switch_line_out),
  .switch_line_oe(switch_line_oe));
`default_nettype wire
